// *** i2h_regs.vh ***
// Purpose: Constants for the temperature and EEPROM I2C host block.
// Assumes: Word registers of 24 bits, reached by index.
// Notes: Definitions only.
`ifndef I2H_REGS_VH
`define I2H_REGS_VH

`define I2H_ADDR_W 8
`define I2H_DATA_W 24
`define I2H_OFS_MODE 8'h00
`define I2H_OFS_CTRL 8'h01
`define I2H_OFS_TADDR 8'h02
`define I2H_OFS_STAT 8'h03

`define I2H_RST_MODE 24'h000000
`define I2H_RST_CTRL 24'h120140
`define I2H_RST_TADDR 24'h92a4c8
`define I2H_RST_STAT 24'h800000

`define I2H_MODE_BYPASS 21
`define I2H_CTRL_DIR_HI 21
`define I2H_CTRL_DIR_LO 20
`define I2H_CTRL_EN 19
`define I2H_CTRL_TRIG 18
`define I2H_CTRL_SSEL 17
`define I2H_CTRL_EEP_HI 8
`define I2H_CTRL_EEP_LO 2
`define I2H_CTRL_SWAP 1
`define I2H_TA_AVG_HI 23
`define I2H_TA_AVG_LO 22
`define I2H_TA_REN 21
`define I2H_TA_CH2_HI 20
`define I2H_TA_CH2_LO 14
`define I2H_TA_CH1_HI 13
`define I2H_TA_CH1_LO 7
`define I2H_TA_CH0_HI 6
`define I2H_TA_CH0_LO 0
`define I2H_ST_AVG_HI 23
`define I2H_ST_AVG_LO 22
`define I2H_ST_NUM 17
`define I2H_ST_PTR_HI 16
`define I2H_ST_PTR_LO 9
`define I2H_ST_LOAD 8

`define I2H_CTRL_WMASK 24'h3e01fe
`define I2H_TA_WMASK 24'hffffff
`define I2H_ST_WMASK 24'hc3fe00
`define I2H_MODE_WMASK 24'h200000

`define I2H_CLK_KHZ 20000
`define I2H_SCL_KHZ 100
`define I2H_QTR_CYC (`I2H_CLK_KHZ / (4 * `I2H_SCL_KHZ))
`define I2H_QTR_W 6

`endif

// *** i2h_avg.v ***
// Purpose: Averages a stream of 8-bit temperature readings.
// Assumes: Select 0 none, 1 two samples, 2 four samples, 3 treated as none.
// Notes: Output updates the cycle after each valid input.
`timescale 1ns/1ns
module i2h_avg (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [1:0] sel_i,
   input wire [7:0] din_i,
   input wire din_valid_i,
   output reg [7:0] avg_o
);
   reg [7:0] h1;
   reg [7:0] h2;
   reg [7:0] h3;
   wire [8:0] sum2;
   wire [9:0] sum4;

   assign sum2 = {1'b0, din_i} + {1'b0, h1};
   assign sum4 = {1'b0, sum2} + {2'b00, h2} + {2'b00, h3};

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         h1 <= 8'h00;
         h2 <= 8'h00;
         h3 <= 8'h00;
         avg_o <= 8'h00;
      end else if (din_valid_i) begin
         h1 <= din_i;
         h2 <= h1;
         h3 <= h2;
         if (sel_i == 2'h1) begin
            avg_o <= sum2[8:1];
         end else if (sel_i == 2'h2) begin
            avg_o <= sum4[9:2];
         end else begin
            avg_o <= din_i;
         end
      end
   end
endmodule // i2h_avg

// *** i2h_host.v ***
// Purpose: Register-controlled I2C host reading sensors and an EEPROM.
// Assumes: One 20 MHz clock; open-drain pins as input, output, enable.
// Notes: Enable low means the pin is pulled low.
`timescale 1ns/1ns
`include "i2h_regs.vh"
module i2h_host (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [23:0] reg_wdata_i,
   output reg [23:0] reg_rdata_o,
   input wire sample_start_i,
   input wire [1:0] tx_channel_i,
   input wire [7:0] onchip_temp_i,
   input wire onchip_temp_valid_i,
   input wire eeprom_load_done_i,
   input wire host_scl_i,
   output wire host_scl_o,
   output wire host_scl_oe_n_o,
   input wire host_sda_i,
   output wire host_sda_o,
   output wire host_sda_oe_n_o,
   input wire slv_scl_i,
   input wire slv_sda_i,
   output wire slv_scl_o,
   output wire slv_scl_oe_n_o,
   output wire slv_sda_o,
   output wire slv_sda_oe_n_o,
   output wire host_busy_o,
   output reg host_nack_o,
   output wire [7:0] ext_temp_avg_o,
   output wire [7:0] onchip_temp_avg_o
);
   localparam S_IDLE = 5'b00001;
   localparam S_START = 5'b00010;
   localparam S_WBYTE = 5'b00100;
   localparam S_RBYTE = 5'b01000;
   localparam S_STOP = 5'b10000;
   localparam P_ADDR = 2'h0;
   localparam P_PTR = 2'h1;
   localparam P_DATA = 2'h2;

   reg [23:0] mode_reg;
   reg [23:0] ctrl_reg;
   reg [23:0] taddr_reg;
   reg [23:0] stat_reg;
   reg [7:0] rd_byte;
   reg [4:0] state;
   reg [1:0] phase;
   reg [1:0] q;
   reg [`I2H_QTR_W-1:0] qcnt;
   reg [3:0] bcnt;
   reg [7:0] shreg;
   reg tr_idx;
   reg scl_low;
   reg sda_low;
   reg scl_m;
   reg scl_s;
   reg sda_m;
   reg sda_s;
   reg rx_valid;
   wire bypass;
   wire host_on;
   wire launch;
   wire qtick;
   wire cur_dir;
   wire wr_ctrl;
   reg [6:0] target;

   function [7:0] i2h_rev;
      input [7:0] d;
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            i2h_rev[k] = d[7-k];
         end
      end
   endfunction

   assign bypass = mode_reg[`I2H_MODE_BYPASS];
   assign host_on = ctrl_reg[`I2H_CTRL_EN] & ~bypass;
   assign launch = (state == S_IDLE) & host_on &
      (ctrl_reg[`I2H_CTRL_SSEL] ? sample_start_i :
       ctrl_reg[`I2H_CTRL_TRIG]);
   assign qtick = (qcnt == `I2H_QTR_CYC - 1) & ~(q == 2'h2 & ~scl_s);
   assign cur_dir = tr_idx ? ctrl_reg[`I2H_CTRL_DIR_HI] :
      ctrl_reg[`I2H_CTRL_DIR_LO];
   assign wr_ctrl = reg_wr_i & (reg_addr_i == `I2H_OFS_CTRL);
   assign host_busy_o = (state != S_IDLE);

   always @* begin
      if (!taddr_reg[`I2H_TA_REN]) begin
         target = ctrl_reg[`I2H_CTRL_EEP_HI:`I2H_CTRL_EEP_LO];
      end else if (tx_channel_i == 2'h2) begin
         target = taddr_reg[`I2H_TA_CH2_HI:`I2H_TA_CH2_LO];
      end else if (tx_channel_i == 2'h1) begin
         target = taddr_reg[`I2H_TA_CH1_HI:`I2H_TA_CH1_LO];
      end else begin
         target = taddr_reg[`I2H_TA_CH0_HI:`I2H_TA_CH0_LO];
      end
   end

   // Pin synchronisers.
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         scl_m <= host_scl_i;
         scl_s <= scl_m;
         sda_m <= host_sda_i;
         sda_s <= sda_m;
      end
   end

   // Register file; reserved bits are masked to zero on write.
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mode_reg <= `I2H_RST_MODE;
         ctrl_reg <= `I2H_RST_CTRL;
         taddr_reg <= `I2H_RST_TADDR;
         stat_reg <= `I2H_RST_STAT;
      end else begin
         if (reg_wr_i && reg_addr_i == `I2H_OFS_MODE) begin
            mode_reg <= reg_wdata_i & `I2H_MODE_WMASK;
         end
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata_i & `I2H_CTRL_WMASK;
         end else if (launch && !ctrl_reg[`I2H_CTRL_SSEL]) begin
            ctrl_reg[`I2H_CTRL_TRIG] <= 1'b0;
         end
         if (reg_wr_i && reg_addr_i == `I2H_OFS_TADDR) begin
            taddr_reg <= reg_wdata_i & `I2H_TA_WMASK;
         end
         if (reg_wr_i && reg_addr_i == `I2H_OFS_STAT) begin
            stat_reg <= reg_wdata_i & `I2H_ST_WMASK;
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 24'h000000;
      end else if (reg_addr_i == `I2H_OFS_MODE) begin
         reg_rdata_o <= mode_reg;
      end else if (reg_addr_i == `I2H_OFS_CTRL) begin
         reg_rdata_o <= ctrl_reg;
      end else if (reg_addr_i == `I2H_OFS_TADDR) begin
         reg_rdata_o <= taddr_reg;
      end else if (reg_addr_i == `I2H_OFS_STAT) begin
         reg_rdata_o <= {stat_reg[23:9], eeprom_load_done_i,
            rd_byte};
      end else begin
         reg_rdata_o <= 24'h000000;
      end
   end

   // Bus engine: four quarters per bit, stretched while SCL is held low.
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state <= S_IDLE;
         phase <= P_ADDR;
         q <= 2'h0;
         qcnt <= {`I2H_QTR_W{1'b0}};
         bcnt <= 4'h0;
         shreg <= 8'h00;
         tr_idx <= 1'b0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rd_byte <= 8'h00;
         rx_valid <= 1'b0;
         host_nack_o <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (state == S_IDLE) begin
            qcnt <= {`I2H_QTR_W{1'b0}};
         end else if (qcnt == `I2H_QTR_CYC - 1) begin
            if (qtick) begin
               qcnt <= {`I2H_QTR_W{1'b0}};
            end
         end else begin
            qcnt <= qcnt + 1'b1;
         end
         case (state)
            S_IDLE: begin
               q <= 2'h0;
               if (launch) begin
                  state <= S_START;
                  tr_idx <= 1'b0;
                  host_nack_o <= 1'b0;
               end
            end
            S_START: begin
               if (qtick) begin
                  q <= q + 1'b1;
                  if (q == 2'h0) begin
                     sda_low <= 1'b0;
                  end else if (q == 2'h1) begin
                     scl_low <= 1'b0;
                  end else if (q == 2'h2) begin
                     sda_low <= 1'b1;
                  end else begin
                     scl_low <= 1'b1;
                     state <= S_WBYTE;
                     phase <= P_ADDR;
                     bcnt <= 4'h0;
                     shreg <= {target, cur_dir};
                  end
               end
            end
            S_WBYTE, S_RBYTE: begin
               if (qtick) begin
                  q <= q + 1'b1;
                  if (q == 2'h0) begin
                     if (state == S_WBYTE && bcnt != 4'h8) begin
                        sda_low <= ~shreg[7];
                     end else begin
                        sda_low <= 1'b0;
                     end
                  end else if (q == 2'h1) begin
                     scl_low <= 1'b0;
                  end else if (q == 2'h2) begin
                     if (bcnt == 4'h8) begin
                        if (state == S_WBYTE && sda_s) begin
                           host_nack_o <= 1'b1;
                        end
                     end else if (state == S_WBYTE) begin
                        shreg <= {shreg[6:0], 1'b0};
                     end else begin
                        shreg <= {shreg[6:0], sda_s};
                     end
                  end else begin
                     // SDA is held past the SCL fall so no false stop appears.
                     scl_low <= 1'b1;
                     bcnt <= bcnt + 1'b1;
                     if (bcnt == 4'h8) begin
                        bcnt <= 4'h0;
                        if (host_nack_o) begin
                           state <= S_STOP;
                        end else if (phase == P_ADDR && !cur_dir) begin
                           state <= S_WBYTE;
                           phase <= P_PTR;
                           shreg <= stat_reg[`I2H_ST_PTR_HI:`I2H_ST_PTR_LO];
                        end else if (phase == P_ADDR) begin
                           state <= S_RBYTE;
                           phase <= P_DATA;
                        end else begin
                           if (phase == P_DATA) begin
                              rd_byte <= ctrl_reg[`I2H_CTRL_SWAP] ?
                                 i2h_rev(shreg) : shreg;
                              rx_valid <= 1'b1;
                           end
                           if (!tr_idx && stat_reg[`I2H_ST_NUM]) begin
                              tr_idx <= 1'b1;
                              state <= S_START;
                           end else begin
                              state <= S_STOP;
                           end
                        end
                     end
                  end
               end
            end
            S_STOP: begin
               if (qtick) begin
                  q <= q + 1'b1;
                  if (q == 2'h0) begin
                     sda_low <= 1'b1;
                  end else if (q == 2'h1) begin
                     scl_low <= 1'b0;
                  end else if (q == 2'h3) begin
                     sda_low <= 1'b0;
                     state <= S_IDLE;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   i2h_avg u_ext_avg (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .sel_i(taddr_reg[`I2H_TA_AVG_HI:`I2H_TA_AVG_LO]),
      .din_i(rd_byte),
      .din_valid_i(rx_valid & taddr_reg[`I2H_TA_REN]),
      .avg_o(ext_temp_avg_o)
   );

   i2h_avg u_chip_avg (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .sel_i(stat_reg[`I2H_ST_AVG_HI:`I2H_ST_AVG_LO]),
      .din_i(onchip_temp_i),
      .din_valid_i(onchip_temp_valid_i),
      .avg_o(onchip_temp_avg_o)
   );

   // Open-drain drivers; in bypass each bus follows the other.
   assign host_scl_o = 1'b0;
   assign host_sda_o = 1'b0;
   assign slv_scl_o = 1'b0;
   assign slv_sda_o = 1'b0;
   assign host_scl_oe_n_o = bypass ? slv_scl_i : ~scl_low;
   assign host_sda_oe_n_o = bypass ? slv_sda_i : ~sda_low;
   assign slv_scl_oe_n_o = bypass ? host_scl_i : 1'b1;
   assign slv_sda_oe_n_o = bypass ? host_sda_i : 1'b1;
endmodule // i2h_host

// *** i2h_host_assertions.sv ***
// Purpose: Port checks for the I2C host.
// Assumes: Quarter bit time of 50 clocks.
// Notes: Bound to every host instance.
`timescale 1ns/1ns
module i2h_host_assertions (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire [7:0] reg_addr_i,
   input wire [23:0] reg_rdata_o,
   input wire eeprom_load_done_i,
   input wire slv_scl_i,
   input wire slv_sda_i,
   input wire host_scl_o,
   input wire host_sda_o,
   input wire host_scl_oe_n_o,
   input wire host_sda_oe_n_o,
   input wire slv_scl_oe_n_o,
   input wire slv_sda_oe_n_o,
   input wire host_busy_o,
   input wire host_nack_o
);
   reg [15:0] busy_cnt;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   always @(posedge ref_clk_i) begin
      if (!rst_n_i || !host_busy_o) begin
         busy_cnt <= 16'h0;
      end else begin
         busy_cnt <= busy_cnt + 16'h1;
      end
   end
   a_idle_quiet: assert property (!host_busy_o &&
      !$past(host_busy_o, 2) && slv_scl_i && slv_sda_i
      |-> host_scl_oe_n_o && host_sda_oe_n_o) else $error("idle drive");
   a_slave_held: assert property (host_busy_o |->
      slv_scl_oe_n_o && slv_sda_oe_n_o) else $error("slave driven");
   a_pins_low: assert property (!host_scl_o && !host_sda_o)
      else $error("pin level");
   a_unmapped_zero: assert property ($past(reg_addr_i) > 8'h03
      |-> reg_rdata_o == 24'h0) else $error("unmapped data");
   a_ctrl_reserved: assert property ($past(reg_addr_i) == 8'h01
      |-> (reg_rdata_o & 24'hc1fe01) == 24'h0) else $error("reserved");
   a_load_flag: assert property ($past(reg_addr_i) == 8'h03
      |-> reg_rdata_o[8] == $past(eeprom_load_done_i)) else $error("load");
   a_start_released: assert property ($rose(host_busy_o)
      |-> host_sda_oe_n_o && host_scl_oe_n_o) else $error("start");
   a_scl_high_time: assert property (host_busy_o
      && $rose(host_scl_oe_n_o) |-> host_scl_oe_n_o[*8]) else $error("scl");
   a_busy_bounded: assert property (busy_cnt < 16'h4e20)
      else $error("busy too long");
   a_nack_cleared: assert property ($rose(host_busy_o)
      |=> !host_nack_o) else $error("nack kept");
   c_launch: cover property ($rose(host_busy_o));
   c_nack: cover property ($rose(host_nack_o));
   c_status: cover property ($past(reg_addr_i) == 8'h03);
endmodule // i2h_host_assertions
bind i2h_host i2h_host_assertions chk_u (.ref_clk_i, .rst_n_i,
   .reg_addr_i, .reg_rdata_o, .eeprom_load_done_i, .slv_scl_i,
   .slv_sda_i, .host_scl_o, .host_sda_o, .host_scl_oe_n_o,
   .host_sda_oe_n_o, .slv_scl_oe_n_o, .slv_sda_oe_n_o, .host_busy_o,
   .host_nack_o);

// *** i2h_slave_model.sv ***
// Purpose: Behavioural I2C slave holding one byte.
// Assumes: Pulled-up wires; one-byte reads ended by a host NACK.
// Notes: A written data byte replaces the byte returned.
`timescale 1ns/1ns
module i2h_slave_model #(
   parameter [6:0] ADDR = 7'h50,
   parameter [7:0] DATA = 8'ha5
) (
   input wire scl_i,
   input wire sda_i,
   output reg sda_oe_n_o
);
   reg [3:0] cnt;
   reg [7:0] sh;
   reg [7:0] mem;
   reg act;
   reg adr;
   reg rd;
   initial begin
      sda_oe_n_o = 1'b1;
      act = 1'b0;
      cnt = 4'h0;
      mem = DATA;
   end
   always @(negedge sda_i) begin
      if (scl_i) begin
         act = 1'b1;
         adr = 1'b1;
         cnt = 4'h0;
      end
   end
   always @(posedge sda_i) begin
      if (scl_i) begin
         act = 1'b0;
      end
   end
   always @(posedge scl_i) begin
      if (act) begin
         if (cnt < 4'h8) sh = {sh[6:0], sda_i};
         cnt = cnt + 4'h1;
      end
   end
   always @(negedge scl_i) begin
      if (act) begin
         sda_oe_n_o = 1'b1;
         if (cnt == 4'h8) begin
            if (adr && sh[7:1] != ADDR) begin
               act = 1'b0;
            end else if (adr || !rd) begin
               sda_oe_n_o = 1'b0;
               if (adr) rd = sh[0];
               else mem = sh;
            end
         end else if (cnt == 4'h9) begin
            if (!adr && rd) act = 1'b0;
            cnt = 4'h0;
            adr = 1'b0;
         end
         if (act && rd && !adr && cnt < 4'h8) sda_oe_n_o = mem[4'h7 - cnt];
      end
   end
endmodule // i2h_slave_model

// *** i2h_host_tb_top.sv ***
// Purpose: Self-checking bench for the I2C host.
// Assumes: Two slave models on a pulled-up host bus.
// Notes: Register rows first, then bus sequences.
`timescale 1ns/1ns
module i2h_host_tb_top;
   reg ref_clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg [7:0] reg_addr_i = 8'h0;
   reg reg_wr_i = 1'b0;
   reg [23:0] reg_wdata_i = 24'h0;
   reg sample_start_i = 1'b0;
   reg [1:0] tx_channel_i = 2'h0;
   reg [7:0] onchip_temp_i = 8'h0;
   reg onchip_temp_valid_i = 1'b0;
   reg eeprom_load_done_i = 1'b0;
   reg s_scl = 1'b1;
   reg s_sda = 1'b1;
   wire [23:0] reg_rdata_o;
   wire [7:0] ext_temp_avg_o, onchip_temp_avg_o;
   wire host_scl_oe_n_o, host_sda_oe_n_o, slv_scl_oe_n_o, slv_sda_oe_n_o;
   wire host_busy_o, host_nack_o, eep_oe_n, sen_oe_n;
   wire scl_w = host_scl_oe_n_o;
   wire sda_w = host_sda_oe_n_o & eep_oe_n & sen_oe_n;
   integer miscompares = 0;
   integer samples_checked = 0;
   integer k, n, j;
   reg [23:0] v;
   reg [56:0] rows [0:12];
   initial begin
      rows[0] = {1'b0, 8'h00, 24'h0, 24'h0};
      rows[1] = {1'b0, 8'h01, 24'h0, 24'h120140};
      rows[2] = {1'b0, 8'h02, 24'h0, 24'h92a4c8};
      rows[3] = {1'b0, 8'h03, 24'h0, 24'h800000};
      rows[4] = {1'b0, 8'h04, 24'h0, 24'h0};
      rows[5] = {1'b1, 8'h09, 24'hffffff, 24'h0};
      rows[6] = {1'b1, 8'h01, 24'hffffff, 24'h3e01fe};
      rows[7] = {1'b1, 8'h01, 24'h0, 24'h0};
      rows[8] = {1'b1, 8'h03, 24'hffffff, 24'hc3fe00};
      rows[9] = {1'b1, 8'h03, 24'h0, 24'h0};
      rows[10] = {1'b1, 8'h00, 24'hffffff, 24'h200000};
      rows[11] = {1'b1, 8'h00, 24'h0, 24'h0};
      rows[12] = {1'b1, 8'h02, 24'hffffff, 24'hffffff};
   end
   always #25 ref_clk_i = ~ref_clk_i;
   i2h_host dut_u (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
      .reg_wdata_i, .reg_rdata_o, .sample_start_i, .tx_channel_i,
      .onchip_temp_i, .onchip_temp_valid_i, .eeprom_load_done_i,
      .host_scl_i(scl_w), .host_scl_o(), .host_scl_oe_n_o,
      .host_sda_i(sda_w), .host_sda_o(), .host_sda_oe_n_o,
      .slv_scl_i(s_scl), .slv_sda_i(s_sda), .slv_scl_o(), .slv_scl_oe_n_o,
      .slv_sda_o(), .slv_sda_oe_n_o, .host_busy_o, .host_nack_o,
      .ext_temp_avg_o, .onchip_temp_avg_o);
   i2h_slave_model #(.ADDR(7'h50), .DATA(8'ha5)) eep_u (.scl_i(scl_w),
      .sda_i(sda_w), .sda_oe_n_o(eep_oe_n));
   i2h_slave_model #(.ADDR(7'h49), .DATA(8'h1d)) sen_u (.scl_i(scl_w),
      .sda_i(sda_w), .sda_oe_n_o(sen_oe_n));
   task tick(input integer c);
      begin
         repeat (c) @(posedge ref_clk_i);
         #2;
      end
   endtask
   task chk(input [23:0] got, input [23:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [23:0] d);
      begin
         reg_addr_i = a;
         reg_wdata_i = d;
         reg_wr_i = 1'b1;
         tick(1);
         reg_wr_i = 1'b0;
         tick(1);
      end
   endtask
   task rd(input [7:0] a);
      begin
         reg_addr_i = a;
         tick(1);
         v = reg_rdata_o;
      end
   endtask
   task summarize;
      begin
         $display("checked %0d mismatched %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task run;
      begin
         for (n = 0; n < 300 && host_busy_o !== 1'b1; n = n + 1) tick(1);
         for (j = 0; j < 20000 && host_busy_o !== 1'b0; j = j + 1) tick(1);
         if (n == 300 || j == 20000) begin
            miscompares = miscompares + 1;
            summarize;
         end
      end
   endtask
   initial begin
      tick(16);
      rst_n_i = 1'b1;
      for (k = 0; k < 13; k = k + 1) begin
         if (rows[k][56]) wr(rows[k][55:48], rows[k][47:24]);
         rd(rows[k][55:48]);
         chk(v, rows[k][23:0]);
      end
      wr(8'h02, 24'h92a4c8);
      wr(8'h01, 24'h1c0140);
      run;
      rd(8'h03);
      chk(v & 24'hff, 24'ha5);
      rd(8'h01);
      chk(v, 24'h180140);
      tx_channel_i = 2'h1;
      wr(8'h02, 24'hb2a4c8);
      wr(8'h01, 24'h1c0142);
      run;
      rd(8'h03);
      chk(v & 24'hff, 24'hb8);
      chk({16'h0, ext_temp_avg_o}, 24'h2e);
      chk({23'h0, host_nack_o}, 24'h0);
      wr(8'h02, 24'h92a4c8);
      wr(8'h03, 24'h02b400);
      wr(8'h01, 24'h2a0140);
      sample_start_i = 1'b1;
      tick(1);
      sample_start_i = 1'b0;
      run;
      rd(8'h03);
      chk(v, 24'h02b45a);
      tx_channel_i = 2'h2;
      wr(8'h03, 24'h0);
      wr(8'h02, 24'h32a4c8);
      wr(8'h01, 24'h1c0140);
      run;
      chk({23'h0, host_nack_o}, 24'h1);
      rd(8'h03);
      chk(v, 24'h5a);
      wr(8'h01, 24'h140140);
      tick(100);
      chk({23'h0, host_busy_o}, 24'h0);
      wr(8'h01, 24'h080140);
      sample_start_i = 1'b1;
      tick(1);
      sample_start_i = 1'b0;
      tick(100);
      chk({23'h0, host_busy_o}, 24'h0);
      wr(8'h03, 24'h400000);
      onchip_temp_i = 8'h40;
      onchip_temp_valid_i = 1'b1;
      tick(1);
      onchip_temp_i = 8'h80;
      tick(1);
      onchip_temp_valid_i = 1'b0;
      tick(1);
      chk({16'h0, onchip_temp_avg_o}, 24'h60);
      eeprom_load_done_i = 1'b1;
      rd(8'h03);
      chk(v & 24'h100, 24'h100);
      wr(8'h00, 24'h200000);
      s_scl = 1'b0;
      tick(1);
      chk({22'h0, host_scl_oe_n_o, slv_scl_oe_n_o}, 24'h0);
      s_scl = 1'b1;
      wr(8'h00, 24'h0);
      wr(8'h01, 24'h1c0140);
      tick(500);
      rst_n_i = 1'b0;
      tick(2);
      rst_n_i = 1'b1;
      rd(8'h01);
      chk(v, 24'h120140);
      chk({23'h0, host_busy_o}, 24'h0);
      summarize;
   end
endmodule // i2h_host_tb_top
